// *** step_logic_pkg.sv ***
// Package for the customizable step logic engine: parameter layout, codes and timing.
// Assumes a single 125 MHz processing clock and operator-written configuration ports.
package step_logic_pkg;

    // -------------------------------------------------------------------------
    // Geometry
    // -------------------------------------------------------------------------
    localparam int NUM_STEPS       = 10;
    localparam int NUM_ROUTED      = 5;
    localparam int PARAMS_PER_STEP = 5;
    localparam int NUM_TERMINALS   = 9;
    localparam int NUM_STATUS      = 8;
    localparam int CODE_W          = 16;
    localparam int TIMER_W         = 16;
    localparam int STEP_IDX_W      = 4;

    // -------------------------------------------------------------------------
    // Position of each setting inside a step's group of five
    // -------------------------------------------------------------------------
    localparam int PARAM_IN1   = 0;
    localparam int PARAM_IN2   = 1;
    localparam int PARAM_OP    = 2;
    localparam int PARAM_TMODE = 3;
    localparam int PARAM_TVAL  = 4;

    // -------------------------------------------------------------------------
    // Input select code bases; the "+1000" forms select the inverted signal
    // -------------------------------------------------------------------------
    localparam logic [CODE_W-1:0] SEL_STEP_BASE    = 16'd2001;
    localparam logic [CODE_W-1:0] SEL_STEP_NEG     = 16'd3001;
    localparam logic [CODE_W-1:0] SEL_TERM_BASE    = 16'd4001;
    localparam logic [CODE_W-1:0] SEL_TERM_NEG     = 16'd5001;
    localparam logic [CODE_W-1:0] SEL_STAT_BASE    = 16'd6000;
    localparam logic [CODE_W-1:0] SEL_STAT_NEG     = 16'd7000;
    localparam logic [CODE_W-1:0] SEL_TERM_FWD_OFS = 16'd9;
    localparam logic [CODE_W-1:0] SEL_TERM_GAP     = 16'd2;

    // -------------------------------------------------------------------------
    // Operation and timer codes
    // -------------------------------------------------------------------------
    localparam logic [3:0] OP_OFF     = 4'h0;
    localparam logic [3:0] OP_THROUGH = 4'h1;
    localparam logic [3:0] OP_AND     = 4'h2;
    localparam logic [3:0] OP_OR      = 4'h3;
    localparam logic [3:0] OP_XOR     = 4'h4;
    localparam logic [3:0] OP_SR      = 4'h5;
    localparam logic [3:0] OP_RISE    = 4'h6;
    localparam logic [3:0] OP_FALL    = 4'h7;
    localparam logic [3:0] OP_EDGE    = 4'h8;
    localparam logic [3:0] OP_HOLD    = 4'h9;
    localparam logic [3:0] OP_CNT     = 4'hA;
    localparam logic [3:0] OP_CNT_RST = 4'hB;
    localparam logic [3:0] OP_TOGGLE  = 4'hC;
    localparam int         NUM_OPS    = 13;

    localparam logic [2:0] TMR_NONE  = 3'h0;
    localparam logic [2:0] TMR_ON    = 3'h1;
    localparam logic [2:0] TMR_OFF   = 3'h2;
    localparam logic [2:0] TMR_PULSE = 3'h3;
    localparam logic [2:0] TMR_RETRIG = 3'h4;
    localparam int         NUM_TMRS  = 5;

    localparam logic MODE_ENABLE = 1'b1;

    // -------------------------------------------------------------------------
    // Timing: one sequence evaluation per 2 ms processing period
    // -------------------------------------------------------------------------
    localparam int CLK_HZ        = 125_000_000;
    localparam int PERIOD_US     = 2000;
    localparam int PERIOD_CYCLES = (CLK_HZ / 1_000_000) * PERIOD_US;

endpackage

// *** step_cfg_if.sv ***
// Interface carrying one step's configuration and its previous result into the step unit.
// Assumes the top module selects the step to evaluate and owns the step state.
`timescale 1ns/1ns
`default_nettype none
interface step_cfg_if;
    import step_logic_pkg::*;
    logic [CODE_W-1:0]  in1_code;
    logic [CODE_W-1:0]  in2_code;
    logic [3:0]         op;
    logic [2:0]         tmode;
    logic [TIMER_W-1:0] tval;
    logic               a;
    logic               b;
    logic               prev_a;
    logic               prev_b;
    logic               logic_q;
    logic               out_q;
    logic [TIMER_W-1:0] tcnt;
    logic               logic_d;
    logic               out_d;
    logic [TIMER_W-1:0] tcnt_d;

    modport top  (output in1_code, in2_code, op, tmode, tval, a, b, prev_a, prev_b, logic_q, out_q, tcnt,
                  input logic_d, out_d, tcnt_d);
    modport unit (input in1_code, in2_code, op, tmode, tval, a, b, prev_a, prev_b, logic_q, out_q, tcnt,
                  output logic_d, out_d, tcnt_d);
endinterface
`default_nettype wire

// *** step_unit.sv ***
// Combinational evaluation of one step: operation stage then timer stage.
// Assumes timer ticks once per processing period; the caller registers all results.
`timescale 1ns/1ns
`default_nettype none
module step_unit
    import step_logic_pkg::*;
(
    step_cfg_if.unit s
);
    logic raw;
    logic rise_a;
    logic fall_a;
    logic [TIMER_W-1:0] one;

    // -------------------------------------------------------------------------
    // Operation stage
    // -------------------------------------------------------------------------
    always_comb begin
        rise_a = s.a & ~s.prev_a;
        fall_a = ~s.a & s.prev_a;
        raw    = 1'b0;
        case (s.op)
            OP_OFF:     raw = 1'b0;
            OP_THROUGH: raw = s.a;
            OP_AND:     raw = s.a & s.b;
            OP_OR:      raw = s.a | s.b;
            OP_XOR:     raw = s.a ^ s.b;
            OP_SR:      raw = ~s.b & (s.a | s.logic_q);
            OP_RISE:    raw = rise_a;
            OP_FALL:    raw = fall_a;
            OP_EDGE:    raw = rise_a | fall_a;
            OP_HOLD:    raw = s.b ? s.a : s.logic_q;
            OP_CNT:     raw = s.logic_q | (rise_a & (s.tcnt + 16'h0001 >= s.tval));
            OP_CNT_RST: raw = ~s.b & (s.logic_q | (rise_a & (s.tcnt + 16'h0001 >= s.tval)));
            OP_TOGGLE:  raw = rise_a ? ~s.logic_q : s.logic_q;
            default:    raw = 1'b0;
        endcase
    end

    // -------------------------------------------------------------------------
    // Timer stage; counters reuse tcnt as the event count.
    // -------------------------------------------------------------------------
    always_comb begin
        one        = {{(TIMER_W-1){1'b0}}, 1'b1};
        s.logic_d  = raw;
        s.out_d    = raw;
        s.tcnt_d   = '0;
        if (s.op == OP_CNT || s.op == OP_CNT_RST) begin
            if (s.op == OP_CNT_RST && s.b)
                s.tcnt_d = '0;
            else if (rise_a && !s.logic_q)
                s.tcnt_d = s.tcnt + one;
            else
                s.tcnt_d = s.tcnt;
        end else begin
            case (s.tmode)
                TMR_ON: begin
                    s.tcnt_d = (raw && s.tcnt < s.tval) ? s.tcnt + one : (raw ? s.tcnt : '0);
                    s.out_d  = raw && (s.tcnt_d >= s.tval);
                end
                TMR_OFF: begin
                    s.tcnt_d = raw ? s.tval : ((s.tcnt != '0) ? s.tcnt - one : '0);
                    s.out_d  = raw || (s.tcnt_d != '0);
                end
                TMR_PULSE: begin
                    if (raw && !s.logic_q)
                        s.tcnt_d = s.tval;
                    else if (s.tcnt != '0)
                        s.tcnt_d = s.tcnt - one;
                    s.out_d = (raw && !s.logic_q && s.tval != '0) || (s.tcnt != '0 && s.tcnt_d != '0);
                end
                TMR_RETRIG: begin
                    if (raw && !s.logic_q)
                        s.tcnt_d = s.tval;
                    else if (s.tcnt != '0)
                        s.tcnt_d = s.tcnt - one;
                    s.out_d = s.tcnt_d != '0;
                end
                default: s.tcnt_d = '0;
            endcase
        end
    end
endmodule
`default_nettype wire

// *** step_logic.sv ***
// Customizable step logic engine: ten configurable steps and five routed outputs.
// Assumes configuration ports are static between periods and inputs are synchronous.
`timescale 1ns/1ns
`default_nettype none
module step_logic
    import step_logic_pkg::*;
#(
    parameter int PERIOD = PERIOD_CYCLES
)(
    input  wire logic                                     CLK_I,
    input  wire logic                                     SRST_I,
    input  wire logic                                     LOGIC_MODE_SELECT_I,
    input  wire logic [NUM_STEPS*PARAMS_PER_STEP*CODE_W-1:0] STEP_SETTING_PARAMS_I,
    input  wire logic [NUM_ROUTED*STEP_IDX_W-1:0]         ROUTED_OUTPUT_SOURCE_SELECT_I,
    input  wire logic [NUM_ROUTED*CODE_W-1:0]             ROUTED_OUTPUT_FUNCTION_SELECT_I,
    input  wire logic [STEP_IDX_W-1:0]                    TIMER_MONITOR_STEP_SELECT_I,
    input  wire logic [NUM_TERMINALS-1:0]                 TERMINAL_INPUTS_I,
    input  wire logic [NUM_STATUS-1:0]                    DRIVE_STATUS_I,
    output logic      [NUM_STEPS-1:0]                     STEP_RESULTS_O,
    output logic      [NUM_ROUTED-1:0]                    ROUTED_OUTPUTS_O,
    output logic      [NUM_ROUTED*CODE_W-1:0]             ROUTED_FUNCTIONS_O,
    output logic      [TIMER_W-1:0]                       TIMER_MONITOR_O,
    output logic                                          PERIOD_DONE_O
);
    // -------------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------------
    typedef enum logic [1:0] {ST_WAIT, ST_EVAL, ST_PUBLISH} phase_t;

    typedef struct packed {
        phase_t                             phase;
        logic [31:0]                        tick;
        logic [STEP_IDX_W-1:0]              idx;
        logic [NUM_STEPS-1:0]               res;
        logic [NUM_STEPS-1:0]               lq;
        logic [NUM_STEPS-1:0]               pa;
        logic [NUM_STEPS-1:0]               pb;
        logic [NUM_STEPS-1:0][TIMER_W-1:0]  tcnt;
        logic [NUM_STEPS-1:0]               res_o;
        logic [NUM_ROUTED-1:0]              rout_o;
        logic [NUM_ROUTED*CODE_W-1:0]       rfun_o;
        logic [TIMER_W-1:0]                 tmon_o;
        logic                               done_o;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    step_cfg_if sc ();

    step_unit u_step (
        .s (sc.unit)
    );

    // Fetches one of the five settings of a step from the flat parameter bus.
    function automatic logic [CODE_W-1:0] param_of(input logic [STEP_IDX_W-1:0] k, input int p);
        return STEP_SETTING_PARAMS_I[(int'(k)*PARAMS_PER_STEP + p)*CODE_W +: CODE_W];
    endfunction

    // Resolves an input select code. The live result vector is used, so a step
    // earlier in this period is seen fresh and a later one from last period.
    function automatic logic pick(input logic [CODE_W-1:0] c, input logic [NUM_STEPS-1:0] r);
        logic [CODE_W-1:0] o;
        logic              v;
        logic              neg;
        v   = 1'b0;
        neg = 1'b0;
        o   = '0;
        if (c >= SEL_STEP_BASE && c < SEL_STEP_BASE + NUM_STEPS) begin
            o = c - SEL_STEP_BASE;
            v = r[o[STEP_IDX_W-1:0]];
        end else if (c >= SEL_STEP_NEG && c < SEL_STEP_NEG + NUM_STEPS) begin
            o   = c - SEL_STEP_NEG;
            v   = r[o[STEP_IDX_W-1:0]];
            neg = 1'b1;
        end else if (c >= SEL_TERM_BASE && c < SEL_TERM_BASE + SEL_TERM_FWD_OFS + SEL_TERM_GAP) begin
            o = c - SEL_TERM_BASE;
            if (o < 16'd7)
                v = TERMINAL_INPUTS_I[o[3:0]];
            else if (o >= SEL_TERM_FWD_OFS)
                v = TERMINAL_INPUTS_I[o[3:0] - 4'd2];
        end else if (c >= SEL_TERM_NEG && c < SEL_TERM_NEG + SEL_TERM_FWD_OFS + SEL_TERM_GAP) begin
            o   = c - SEL_TERM_NEG;
            neg = 1'b1;
            if (o < 16'd7)
                v = TERMINAL_INPUTS_I[o[3:0]];
            else if (o >= SEL_TERM_FWD_OFS)
                v = TERMINAL_INPUTS_I[o[3:0] - 4'd2];
            else
                neg = 1'b0;
        end else if (c >= SEL_STAT_BASE && c < SEL_STAT_BASE + NUM_STATUS) begin
            o = c - SEL_STAT_BASE;
            v = DRIVE_STATUS_I[o[2:0]];
        end else if (c >= SEL_STAT_NEG && c < SEL_STAT_NEG + NUM_STATUS) begin
            o   = c - SEL_STAT_NEG;
            v   = DRIVE_STATUS_I[o[2:0]];
            neg = 1'b1;
        end
        return v ^ neg;
    endfunction

    // -------------------------------------------------------------------------
    // Next-state logic
    // -------------------------------------------------------------------------
    always_comb begin
        st_nxt      = st_r;
        st_nxt.done_o = 1'b0;
        sc.in1_code = param_of(st_r.idx, PARAM_IN1);
        sc.in2_code = param_of(st_r.idx, PARAM_IN2);
        sc.op       = param_of(st_r.idx, PARAM_OP)[3:0];
        sc.tmode    = param_of(st_r.idx, PARAM_TMODE)[2:0];
        sc.tval     = param_of(st_r.idx, PARAM_TVAL)[TIMER_W-1:0];
        sc.a        = pick(sc.in1_code, st_r.res);
        sc.b        = pick(sc.in2_code, st_r.res);
        sc.prev_a   = st_r.pa[st_r.idx];
        sc.prev_b   = st_r.pb[st_r.idx];
        sc.logic_q  = st_r.lq[st_r.idx];
        sc.out_q    = st_r.res[st_r.idx];
        sc.tcnt     = st_r.tcnt[st_r.idx];

        if (st_r.tick + 32'd1 >= 32'(PERIOD))
            st_nxt.tick = '0;
        else
            st_nxt.tick = st_r.tick + 32'd1;

        if (LOGIC_MODE_SELECT_I != MODE_ENABLE) begin
            st_nxt.phase  = ST_WAIT;
            st_nxt.idx    = '0;
            st_nxt.res    = '0;
            st_nxt.lq     = '0;
            st_nxt.pa     = '0;
            st_nxt.pb     = '0;
            st_nxt.tcnt   = '0;
            st_nxt.res_o  = '0;
            st_nxt.rout_o = '0;
        end else begin
            case (st_r.phase)
                ST_WAIT: begin
                    if (st_r.tick == '0) begin
                        st_nxt.phase = ST_EVAL;
                        st_nxt.idx   = '0;
                    end
                end
                ST_EVAL: begin
                    st_nxt.res[st_r.idx]  = sc.out_d;
                    st_nxt.lq[st_r.idx]   = sc.logic_d;
                    st_nxt.pa[st_r.idx]   = sc.a;
                    st_nxt.pb[st_r.idx]   = sc.b;
                    st_nxt.tcnt[st_r.idx] = sc.tcnt_d;
                    if (st_r.idx == STEP_IDX_W'(NUM_STEPS - 1))
                        st_nxt.phase = ST_PUBLISH;
                    else
                        st_nxt.idx = st_r.idx + 1'b1;
                end
                ST_PUBLISH: begin
                    st_nxt.res_o  = st_r.res;
                    for (int i = 0; i < NUM_ROUTED; i++) begin
                        st_nxt.rout_o[i] = pick(SEL_STEP_BASE + 16'(ROUTED_OUTPUT_SOURCE_SELECT_I[i*STEP_IDX_W +: STEP_IDX_W]),
                                                st_r.res);
                    end
                    st_nxt.done_o = 1'b1;
                    st_nxt.phase  = ST_WAIT;
                end
                default: st_nxt.phase = ST_WAIT;
            endcase
        end
        st_nxt.rfun_o = ROUTED_OUTPUT_FUNCTION_SELECT_I;
        // Timers are cleared while disabled, so the monitor must read zero at once.
        if (LOGIC_MODE_SELECT_I == MODE_ENABLE && TIMER_MONITOR_STEP_SELECT_I < STEP_IDX_W'(NUM_STEPS))
            st_nxt.tmon_o = st_r.tcnt[TIMER_MONITOR_STEP_SELECT_I];
        else
            st_nxt.tmon_o = '0;
    end

    // -------------------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------------------
    always_ff @(posedge CLK_I) begin
        if (SRST_I)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign STEP_RESULTS_O     = st_r.res_o;
    assign ROUTED_OUTPUTS_O   = st_r.rout_o;
    assign ROUTED_FUNCTIONS_O = st_r.rfun_o;
    assign TIMER_MONITOR_O    = st_r.tmon_o;
    assign PERIOD_DONE_O      = st_r.done_o;
endmodule
`default_nettype wire

// *** step_logic_chk.sv ***
// Concurrent checks on the ports of the step logic engine, bound to its top module.
// Assumes the bench keeps every routed source index within 0 to 9.
`timescale 1ns/1ns
`default_nettype none
module step_logic_chk
    import step_logic_pkg::*;
#(
    parameter int PERIOD = PERIOD_CYCLES
)(
    input wire logic                                          CLK_I,
    input wire logic                                          SRST_I,
    input wire logic                                          LOGIC_MODE_SELECT_I,
    input wire logic [NUM_STEPS*PARAMS_PER_STEP*CODE_W-1:0]   STEP_SETTING_PARAMS_I,
    input wire logic [NUM_ROUTED*STEP_IDX_W-1:0]              ROUTED_OUTPUT_SOURCE_SELECT_I,
    input wire logic [NUM_ROUTED*CODE_W-1:0]                  ROUTED_OUTPUT_FUNCTION_SELECT_I,
    input wire logic [STEP_IDX_W-1:0]                         TIMER_MONITOR_STEP_SELECT_I,
    input wire logic [NUM_TERMINALS-1:0]                      TERMINAL_INPUTS_I,
    input wire logic [NUM_STATUS-1:0]                         DRIVE_STATUS_I,
    input wire logic [NUM_STEPS-1:0]                          STEP_RESULTS_O,
    input wire logic [NUM_ROUTED-1:0]                         ROUTED_OUTPUTS_O,
    input wire logic [NUM_ROUTED*CODE_W-1:0]                  ROUTED_FUNCTIONS_O,
    input wire logic [TIMER_W-1:0]                            TIMER_MONITOR_O,
    input wire logic                                          PERIOD_DONE_O
);
    // -------------------------------------------------------------------------
    // Helper logic
    // -------------------------------------------------------------------------
    // The gap is only judged while the mode stayed on since the last pulse.
    logic [31:0]           gap_r;
    logic [31:0]           wait_r;
    logic                  armed_r;
    logic [NUM_ROUTED-1:0] routed_exp;
    logic [NUM_STEPS-1:0]  off_mask;

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            gap_r   <= 32'h0000_0000;
            wait_r  <= 32'h0000_0000;
            armed_r <= 1'b0;
        end else begin
            gap_r   <= PERIOD_DONE_O ? 32'h0000_0001 : gap_r + 32'h0000_0001;
            wait_r  <= (!LOGIC_MODE_SELECT_I || PERIOD_DONE_O) ? 32'h0000_0000 : wait_r + 32'h0000_0001;
            armed_r <= LOGIC_MODE_SELECT_I & (PERIOD_DONE_O | armed_r);
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_ROUTED; i++)
            routed_exp[i] = STEP_RESULTS_O[ROUTED_OUTPUT_SOURCE_SELECT_I[i*STEP_IDX_W +: STEP_IDX_W]];
        for (int k = 0; k < NUM_STEPS; k++)
            off_mask[k] = (STEP_SETTING_PARAMS_I[(k*PARAMS_PER_STEP+PARAM_OP)*CODE_W +: 4] == OP_OFF);
    end

    // -------------------------------------------------------------------------
    // Properties
    // -------------------------------------------------------------------------
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (SRST_I);

    sequence s_mode_off;
        !LOGIC_MODE_SELECT_I;
    endsequence
    sequence s_mode_steady;
        LOGIC_MODE_SELECT_I ##1 LOGIC_MODE_SELECT_I;
    endsequence

    a_off_quiet: assert property (s_mode_off |=> STEP_RESULTS_O == '0 && ROUTED_OUTPUTS_O == '0
        && TIMER_MONITOR_O == '0) else $error("outputs active while engine disabled");
    a_off_no_done: assert property (s_mode_off |=> !PERIOD_DONE_O)
        else $error("done pulse while engine disabled");
    a_hold_between: assert property ((s_mode_steady ##1 !PERIOD_DONE_O) |-> $stable(STEP_RESULTS_O)
        && $stable(ROUTED_OUTPUTS_O)) else $error("outputs moved outside a publish");
    a_done_single: assert property (PERIOD_DONE_O |=> !PERIOD_DONE_O)
        else $error("done pulse longer than one cycle");
    a_period_gap: assert property (PERIOD_DONE_O && armed_r |-> gap_r == PERIOD)
        else $error("publish spacing differs from the period");
    a_first_bound: assert property (wait_r <= PERIOD + 12)
        else $error("no publish within a period of enabling");
    a_routed_pick: assert property (PERIOD_DONE_O |-> ROUTED_OUTPUTS_O == routed_exp)
        else $error("routed output does not follow its step");
    a_op_off: assert property (PERIOD_DONE_O |-> (STEP_RESULTS_O & off_mask) == '0)
        else $error("step with no function produced a result");
    a_monitor_range: assert property ((TIMER_MONITOR_STEP_SELECT_I > 4'h9) ##1 (TIMER_MONITOR_STEP_SELECT_I > 4'h9)
        |-> TIMER_MONITOR_O == '0) else $error("timer monitor nonzero for an absent step");
endmodule

bind step_logic step_logic_chk #(.PERIOD(PERIOD)) u_chk (
    .CLK_I(CLK_I), .SRST_I(SRST_I), .LOGIC_MODE_SELECT_I(LOGIC_MODE_SELECT_I),
    .STEP_SETTING_PARAMS_I(STEP_SETTING_PARAMS_I), .ROUTED_OUTPUT_SOURCE_SELECT_I(ROUTED_OUTPUT_SOURCE_SELECT_I),
    .ROUTED_OUTPUT_FUNCTION_SELECT_I(ROUTED_OUTPUT_FUNCTION_SELECT_I),
    .TIMER_MONITOR_STEP_SELECT_I(TIMER_MONITOR_STEP_SELECT_I), .TERMINAL_INPUTS_I(TERMINAL_INPUTS_I),
    .DRIVE_STATUS_I(DRIVE_STATUS_I), .STEP_RESULTS_O(STEP_RESULTS_O), .ROUTED_OUTPUTS_O(ROUTED_OUTPUTS_O),
    .ROUTED_FUNCTIONS_O(ROUTED_FUNCTIONS_O), .TIMER_MONITOR_O(TIMER_MONITOR_O), .PERIOD_DONE_O(PERIOD_DONE_O));
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the step logic engine with a shortened processing period.
// Assumes the checker is bound to the engine from its own file.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import step_logic_pkg::*;
    localparam int PER = 40;

    logic         clk;
    logic         srst;
    logic         mode;
    logic [799:0] params;
    logic [19:0]  src;
    logic [79:0]  fsel;
    logic [3:0]   mon_sel;
    logic [8:0]   term;
    logic [7:0]   stat;
    logic [9:0]   results;
    logic [4:0]   routed;
    logic [79:0]  funcs;
    logic [15:0]  mon;
    logic         done;
    int           mismatches = 0;
    int           check_count = 0;

    always #4 clk = ~clk;

    step_logic #(.PERIOD(PER)) dut (
        .CLK_I(clk), .SRST_I(srst), .LOGIC_MODE_SELECT_I(mode), .STEP_SETTING_PARAMS_I(params),
        .ROUTED_OUTPUT_SOURCE_SELECT_I(src), .ROUTED_OUTPUT_FUNCTION_SELECT_I(fsel),
        .TIMER_MONITOR_STEP_SELECT_I(mon_sel), .TERMINAL_INPUTS_I(term), .DRIVE_STATUS_I(stat),
        .STEP_RESULTS_O(results), .ROUTED_OUTPUTS_O(routed), .ROUTED_FUNCTIONS_O(funcs),
        .TIMER_MONITOR_O(mon), .PERIOD_DONE_O(done));

    // -------------------------------------------------------------------------
    // Tasks
    // -------------------------------------------------------------------------
    task automatic check(input string what, input logic [79:0] seen, input logic [79:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic set_step(input int k, input logic [15:0] a, input logic [15:0] b, input logic [3:0] op);
        params[(k*5+PARAM_IN1)*CODE_W +: CODE_W]   = a;
        params[(k*5+PARAM_IN2)*CODE_W +: CODE_W]   = b;
        params[(k*5+PARAM_OP)*CODE_W +: CODE_W]    = {12'h000, op};
        params[(k*5+PARAM_TMODE)*CODE_W +: CODE_W] = {13'h0000, TMR_NONE};
        params[(k*5+PARAM_TVAL)*CODE_W +: CODE_W]  = 16'h0000;
    endtask

    // Bounded so a missing publish ends as a mismatch, not a hang.
    task automatic wait_done(output int gap);
        gap = 0;
        do begin
            @(posedge clk);
            #1;
            gap++;
        end while (done !== 1'b1 && gap < 200);
        if (gap >= 200) check("done pulse", 80'h0, 80'h1);
    endtask

    // Routed outputs take steps 10, 7, 4, 2 and 1 in order.
    task automatic check_pub(input logic [9:0] exp);
        check("step results", results, exp);
        check("routed outputs", routed, {exp[0], exp[1], exp[3], exp[6], exp[9]});
        check("routed functions", funcs, fsel);
    endtask

    task automatic wrap_up;
        if (mismatches == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge clk);
        mismatches++;
        wrap_up();
    end

    // -------------------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------------------
    initial begin
        int gap;
        int seen;
        clk = 1'b0;
        srst = 1'b1;
        mode = 1'b0;
        params = '0;
        src = 20'h0_1369;
        fsel = 80'h0005_0004_0003_0002_0001;
        mon_sel = 4'hC;
        term = 9'h081;
        stat = 8'h01;
        repeat (10) @(negedge clk);
        check("results in reset", results, 80'h0);
        srst = 1'b0;
        seen = 0;
        repeat (60) begin
            @(posedge clk);
            #1;
            if (done === 1'b1) seen++;
        end
        check("done while disabled", seen, 80'h0);
        check("results while disabled", results, 80'h0);
        @(negedge clk);
        set_step(0, SEL_TERM_BASE, SEL_TERM_BASE + 16'h0001, OP_OFF);
        set_step(1, SEL_TERM_BASE, SEL_TERM_BASE, OP_THROUGH);
        set_step(2, SEL_TERM_BASE, SEL_TERM_BASE + 16'h0001, OP_AND);
        set_step(3, SEL_TERM_BASE, SEL_TERM_BASE + 16'h0001, OP_OR);
        set_step(4, SEL_TERM_NEG + 16'h0001, SEL_TERM_BASE, OP_THROUGH);
        set_step(5, SEL_STEP_BASE + 16'h0001, SEL_STAT_BASE, OP_AND);
        set_step(6, SEL_STEP_BASE + 16'h0007, SEL_TERM_BASE, OP_THROUGH);
        set_step(7, SEL_TERM_BASE, SEL_TERM_BASE, OP_THROUGH);
        set_step(8, SEL_TERM_BASE + 16'h0009, SEL_TERM_BASE, OP_THROUGH);
        set_step(9, SEL_STAT_NEG, SEL_TERM_BASE, OP_THROUGH);
        mode = 1'b1;
        wait_done(gap);
        check_pub(10'h1BA);
        wait_done(gap);
        check("period", gap, PER);
        check_pub(10'h1FA);
        @(negedge clk);
        term = 9'h002;
        stat = 8'h00;
        repeat (5) @(posedge clk);
        #1;
        check("held results", results, 10'h1FA);
        wait_done(gap);
        check_pub(10'h248);
        // Step 1 becomes an on-delay of two periods on X2, watched on the monitor.
        @(negedge clk);
        set_step(0, SEL_TERM_BASE + 16'h0001, SEL_TERM_BASE, OP_THROUGH);
        params[PARAM_TMODE*CODE_W +: CODE_W] = {13'h0000, TMR_ON};
        params[PARAM_TVAL*CODE_W +: CODE_W]  = 16'h0002;
        mon_sel = 4'h0;
        wait_done(gap);
        check_pub(10'h208);
        check("timer monitor", mon, 80'h1);
        wait_done(gap);
        check_pub(10'h209);
        check("timer monitor", mon, 80'h2);
        @(negedge clk);
        mode = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check("outputs after disable", {routed, results, mon}, 80'h0);
        seen = 0;
        repeat (60) begin
            @(posedge clk);
            #1;
            if (done === 1'b1) seen++;
        end
        check("done after disable", seen, 80'h0);
        wrap_up();
    end
endmodule
`default_nettype wire
